/* File: pmfl_pkg.sv */
/*
 * Shared constants and carrier types for the fault-log readout tail and the
 * identification commands of the power system manager.
 * Assumes a single 100 MHz clock domain; all users import pmfl_pkg::*.
 */
package pmfl_pkg;

    // Command codes answered by this block
    localparam logic [7:0] PMFL_CMD_CAPABILITY = 8'h19;
    localparam logic [7:0] PMFL_CMD_REVISION = 8'h98;
    localparam logic [7:0] PMFL_CMD_INFO = 8'hb6;
    localparam logic [7:0] PMFL_CMD_LOT = 8'hc2;
    localparam logic [7:0] PMFL_CMD_IDENTITY = 8'he7;

    // Capability byte fields
    localparam int PMFL_CAP_PEC_BIT = 7;
    localparam int PMFL_CAP_SCL_LSB = 5;
    localparam int PMFL_CAP_ALERT_BIT = 4;
    localparam logic [1:0] PMFL_CAP_SCL_400K = 2'h1;
    localparam logic [7:0] PMFL_CAPABILITY_VALUE = 8'hb0;
    localparam logic [7:0] PMFL_REVISION_VALUE = 8'h11;

    // Information word: only the ECC flag is defined
    localparam int PMFL_INFO_ECC_BIT = 5;

    // Fault-log image positions
    localparam logic [7:0] PMFL_IMG_TAIL_FIRST = 8'hc8;
    localparam logic [7:0] PMFL_IMG_CH0_BASE = 8'hc3;
    localparam logic [7:0] PMFL_IMG_FULL_LAST = 8'hd0;
    localparam logic [7:0] PMFL_IMG_PART_FIRST = 8'hd1;
    localparam logic [7:0] PMFL_IMG_PART_LAST = 8'hed;
    localparam logic [7:0] PMFL_IMG_PAD_FIRST = 8'hee;
    localparam logic [7:0] PMFL_IMG_PAD_LAST = 8'hfe;
    localparam logic [7:0] PMFL_IMG_FINAL = 8'hff;
    localparam logic [7:0] PMFL_PAD_VALUE = 8'h00;
    localparam logic [5:0] PMFL_LOOP_TOP = 6'h39;
    localparam logic [5:0] PMFL_LOOP_BYTES = 6'h3a;
    localparam logic [3:0] PMFL_CHAN_BYTES = 4'hc;

    // Reset values
    localparam logic PMFL_RAM_STATUS_RST = 1'b0;
    localparam logic PMFL_ECC_CLEAN_RST = 1'b1;

    // One channel's telemetry snapshot as logged
    typedef struct packed {
        logic [15:0] pout;
        logic [15:0] iout;
        logic [7:0] status_iout;
        logic [7:0] status_temp;
        logic [15:0] temp;
        logic [7:0] status_mfr;
        logic [7:0] status_vout;
        logic [15:0] vout;
    } pmfl_chan_s;

    typedef pmfl_chan_s [3:0] pmfl_chan_arr_t;

    // Decoded read command from the bus engine
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] page;
        logic is_word;
    } pmfl_cmd_s;

    // Answer to a read command
    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } pmfl_rsp_s;

    // Answer to an image byte read
    typedef struct packed {
        logic loop_valid;
        logic [5:0] loop_num;
        logic [7:0] data;
    } pmfl_img_s;

endpackage

/* File: pmfl_image_map.sv */
/*
 * Combinational map from a fault-log image position to its byte, for the
 * tail of the image (positions C8..FF).
 * Assumes the telemetry snapshot is stable while a position is looked up.
 */
`timescale 1ns/1ns
`default_nettype none
module pmfl_image_map
    import pmfl_pkg::*;
(
    input wire logic [7:0] idx,
    input wire pmfl_chan_arr_t chans,
    input wire logic [15:0] die_temp,
    output pmfl_img_s img
);

    // One channel's logged byte at offset 0..11 of its 12-byte group
    function automatic logic [7:0] chan_byte(input pmfl_chan_s c, input logic [3:0] off);
        case (off)
            4'h0: chan_byte = c.pout[15:8];
            4'h1: chan_byte = c.pout[7:0];
            4'h2: chan_byte = c.iout[15:8];
            4'h3: chan_byte = c.iout[7:0];
            4'h4: chan_byte = c.status_iout;
            4'h5: chan_byte = c.status_temp;
            4'h6: chan_byte = c.temp[15:8];
            4'h7: chan_byte = c.temp[7:0];
            4'h8: chan_byte = c.status_mfr;
            4'h9: chan_byte = c.status_vout;
            4'ha: chan_byte = c.vout[15:8];
            4'hb: chan_byte = c.vout[7:0];
            default: chan_byte = PMFL_PAD_VALUE;
        endcase
    endfunction

    // Region decode
    wire logic in_ch0 = (idx >= PMFL_IMG_TAIL_FIRST) && (idx < PMFL_IMG_FULL_LAST - 8'h1);
    wire logic in_full = (idx >= PMFL_IMG_TAIL_FIRST) && (idx <= PMFL_IMG_FULL_LAST);
    wire logic in_part = (idx >= PMFL_IMG_PART_FIRST) && (idx <= PMFL_IMG_PART_LAST);

    // Partial loop walks channels 3, 2, 1 in 12-byte groups
    wire logic [7:0] part_rel = idx - PMFL_IMG_PART_FIRST;
    wire logic [1:0] part_grp = 2'(part_rel / 8'(PMFL_CHAN_BYTES));
    wire logic [3:0] part_off = 4'(part_rel % 8'(PMFL_CHAN_BYTES));
    wire logic [1:0] part_ch = 2'h3 - part_grp;
    wire logic [3:0] ch0_off = 4'(idx - PMFL_IMG_CH0_BASE);

    // Full loop closes with channel 0 then die temperature, low byte at D0
    wire logic [7:0] full_byte = in_ch0 ? chan_byte(chans[0], ch0_off) :
                                 (idx == PMFL_IMG_FULL_LAST) ? die_temp[7:0] : die_temp[15:8];
    wire logic [5:0] full_num = 6'(PMFL_IMG_FULL_LAST - idx);
    // Partial loop counts down from 57
    wire logic [5:0] part_num = PMFL_LOOP_TOP - 6'(part_rel);

    // Everything past the last logged byte reads as padding
    assign img.data = in_full ? full_byte :
                      in_part ? chan_byte(chans[part_ch], part_off) : PMFL_PAD_VALUE;
    assign img.loop_num = in_full ? full_num : in_part ? part_num : 6'h0;
    assign img.loop_valid = in_full | in_part;

endmodule // pmfl_image_map
`default_nettype wire

/* File: pmfl_top.sv */
/*
 * Fault-log image tail readout and identification/information command
 * answers of the power system manager.
 * Assumes an upstream bus engine on ref_clk that hands over decoded reads
 * and image byte requests, and an NVM controller on the same clock.
 */
//
// Behaviour
// - Full loop ends with channel 0 bytes, then die temperature low byte at D0.
// - Partial loop starts at D1, loop numbers count down from 57, 58-byte loops.
// - Image bytes EE through FE read as zero.
// - Unpaged byte read of 0x19 returns fixed capability value 0xB0.
// - Capability: PEC bit 1, speed 01b for 400kHz, alert 1, low nibble 0.
// - Unpaged byte read of 0x98 returns revision value 0x11.
// - Unpaged word read of 0xE7 returns the stored maker identity word.
// - Paged byte read of 0xC2 returns that page's stored lot code.
// - Info word bit 5 shows ECC clean, refreshed on reset, restore, bulk read.
`timescale 1ns/1ns
`default_nettype none
module pmfl_top
    import pmfl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire pmfl_cmd_s cmd,
    output pmfl_rsp_s rsp,
    output logic rsp_valid,
    input wire logic img_rd,
    input wire logic [7:0] img_idx,
    output pmfl_img_s img_rsp,
    output logic img_rsp_valid,
    input wire pmfl_chan_arr_t chans,
    input wire logic [15:0] die_temp,
    input wire logic [15:0] maker_identity_word,
    input wire logic [3:0][7:0] lot_codes,
    input wire logic ecc_clean,
    input wire logic restore_done,
    input wire logic bulk_read_done,
    input wire logic fault_log_written,
    output logic fault_log_ram_status
);

    // Capability byte assembled from its fields, ANDed with the fixed value
    localparam logic [7:0] CAP_BUILT = (8'h1 << PMFL_CAP_PEC_BIT)
        | (8'(PMFL_CAP_SCL_400K) << PMFL_CAP_SCL_LSB)
        | (8'h1 << PMFL_CAP_ALERT_BIT);
    localparam logic [7:0] CAP_BYTE = CAP_BUILT & PMFL_CAPABILITY_VALUE;

    logic rsp_valid_r;
    pmfl_rsp_s rsp_r;
    logic img_valid_r;
    pmfl_img_s img_r;
    logic ram_status_r;
    logic ecc_clean_r;
    logic ecc_load_r;
    pmfl_img_s img_map;

    pmfl_image_map u_map (
        .idx(img_idx),
        .chans(chans),
        .die_temp(die_temp),
        .img(img_map)
    );

    // Command decode: each code accepts only its own transfer size
    wire logic hit_cap = (cmd.code == PMFL_CMD_CAPABILITY) && !cmd.is_word;
    wire logic hit_rev = (cmd.code == PMFL_CMD_REVISION) && !cmd.is_word;
    wire logic hit_info = (cmd.code == PMFL_CMD_INFO) && cmd.is_word;
    wire logic hit_lot = (cmd.code == PMFL_CMD_LOT) && !cmd.is_word;
    wire logic hit_id = (cmd.code == PMFL_CMD_IDENTITY) && cmd.is_word;
    wire logic cmd_hit = hit_cap | hit_rev | hit_info | hit_lot | hit_id;

    // Info word: reserved bits read zero, only the ECC flag is live
    wire logic [15:0] info_word = 16'(ecc_clean_r) << PMFL_INFO_ECC_BIT;

    // Answer selection; unknown codes or wrong size answer zero with no ack
    wire logic [15:0] cmd_data =
        hit_cap ? {8'h00, CAP_BYTE} :
        hit_rev ? {8'h00, PMFL_REVISION_VALUE} :
        hit_info ? info_word :
        hit_lot ? {8'h00, lot_codes[cmd.page]} :
        hit_id ? maker_identity_word : 16'h0000;

    // Command answer registered one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rsp_valid_r <= cmd_valid;
            if (cmd_valid) begin
                rsp_r.ack <= cmd_hit;
                rsp_r.data <= cmd_data;
            end
        end
    end

    // Image byte answer registered one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            img_valid_r <= 1'b0;
            img_r <= '0;
        end else begin
            img_valid_r <= img_rd;
            if (img_rd) begin
                img_r <= img_map;
            end
        end
    end

    // Final-byte read ends a readout; a new capture in the same cycle wins
    wire logic final_read = img_rd && (img_idx == PMFL_IMG_FINAL);
    wire logic ram_status_nxt = fault_log_written | (ram_status_r & ~final_read);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ram_status_r <= PMFL_RAM_STATUS_RST;
        end else begin
            ram_status_r <= ram_status_nxt;
        end
    end

    // ECC flag is sampled the cycle after reset release, so reset loads
    // only constants; restore and bulk read resample it later
    wire logic ecc_sample = ecc_load_r | restore_done | bulk_read_done;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ecc_load_r <= 1'b1;
            ecc_clean_r <= PMFL_ECC_CLEAN_RST;
        end else begin
            ecc_load_r <= 1'b0;
            if (ecc_sample) begin
                ecc_clean_r <= ecc_clean;
            end
        end
    end

    assign rsp = rsp_r;
    assign rsp_valid = rsp_valid_r;
    assign img_rsp = img_r;
    assign img_rsp_valid = img_valid_r;
    assign fault_log_ram_status = ram_status_r;

endmodule // pmfl_top
`default_nettype wire

/* File: pmfl_host_model.sv */
/* Host-side read requester for the fault-log tail block.
   Assumes tasks are called just after a rising edge of ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module pmfl_host_model
    import pmfl_pkg::*;
(
    input wire logic ref_clk,
    output logic cmd_valid,
    output pmfl_cmd_s cmd,
    output logic img_rd,
    output logic [7:0] img_idx
);
    // Quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        img_rd = 1'b0;
        cmd = '0;
        img_idx = 8'h00;
    end
    // One request per edge; the next call or idle() replaces it
    task automatic rd_cmd(input logic [7:0] c, input logic [1:0] p, input logic w);
        img_rd = 1'b0;
        cmd_valid = 1'b1;
        cmd = '{c, p, w};
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd_img(input logic [7:0] i);
        cmd_valid = 1'b0;
        img_rd = 1'b1;
        img_idx = i;
        @(posedge ref_clk);
        #1;
    endtask
    // Released fields flip so a stale value cannot pass for a live one
    task automatic idle();
        cmd_valid = 1'b0;
        img_rd = 1'b0;
        cmd = ~cmd;
        img_idx = ~img_idx;
    endtask
endmodule // pmfl_host_model
`default_nettype wire

/* File: pmfl_top_sva.sv */
/* Port assertions for pmfl_top.
   Assumes the single ref_clk domain with synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module pmfl_top_sva
    import pmfl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire pmfl_cmd_s cmd,
    input wire pmfl_rsp_s rsp,
    input wire logic rsp_valid,
    input wire logic img_rd,
    input wire logic [7:0] img_idx,
    input wire pmfl_img_s img_rsp,
    input wire logic img_rsp_valid,
    input wire pmfl_chan_arr_t chans,
    input wire logic [15:0] die_temp,
    input wire logic [15:0] maker_identity_word,
    input wire logic [3:0][7:0] lot_codes,
    input wire logic fault_log_written,
    input wire logic fault_log_ram_status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Decodes shared by the properties
    wire logic [7:0] lot_sel = lot_codes[cmd.page];
    wire logic cmd_byte = cmd_valid && !cmd.is_word;
    wire logic pad_rd = img_rd && img_idx >= 8'hee && img_idx <= 8'hfe;
    a_rsp_next: assert property (cmd_valid |=> rsp_valid)
        else $error("command not answered next cycle");
    a_rsp_quiet: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without request");
    a_cap_fixed: assert property (
        cmd_byte && cmd.code == 8'h19 |=> rsp == 17'h100b0)
        else $error("capability byte wrong");
    a_rev_fixed: assert property (cmd_byte && cmd.code == 8'h98 |=> rsp == 17'h10011)
        else $error("revision byte wrong");
    a_id_word: assert property (cmd_valid && cmd.is_word && cmd.code == 8'he7
        |=> rsp == {1'b1, $past(maker_identity_word)}) else $error("identity word wrong");
    a_lot_page: assert property (cmd_byte && cmd.code == 8'hc2
        |=> rsp == {9'h100, $past(lot_sel)}) else $error("lot code wrong");
    a_pad_zero: assert property (pad_rd |=> img_rsp_valid && img_rsp == 15'h0000)
        else $error("pad byte not zero");
    a_temp_low: assert property (img_rd && img_idx == 8'hd0
        |=> img_rsp == {7'h40, $past(die_temp[7:0])}) else $error("loop end byte wrong");
    a_part_top: assert property (img_rd && img_idx == 8'hd1
        |=> img_rsp == {7'h79, $past(chans[3].pout[15:8])}) else $error("partial start wrong");
    a_final_clr: assert property (img_rd && img_idx == 8'hff && !fault_log_written
        |=> !fault_log_ram_status) else $error("final read did not clear status");
    c_final: cover property (img_rd && img_idx == 8'hff ##1 !fault_log_ram_status);
    c_ident: cover property (cmd_valid && cmd.code == 8'he7);
    c_set_wins: cover property (fault_log_written && img_rd && img_idx == 8'hff);
endmodule // pmfl_top_sva
bind pmfl_top pmfl_top_sva chk (.*);
`default_nettype wire

/* File: tb_pmfl_top.sv */
/* Self-checking bench for pmfl_top driven through the host model.
   Assumes pmfl_pkg, the host model and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_pmfl_top
    import pmfl_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid, img_rd, rsp_valid, img_rsp_valid, ecc_clean, restore_done;
    logic bulk_read_done, fault_log_written, fault_log_ram_status;
    logic [7:0] img_idx;
    logic [15:0] die_temp, maker_identity_word;
    logic [3:0][7:0] lot_codes;
    pmfl_cmd_s cmd;
    pmfl_rsp_s rsp;
    pmfl_img_s img_rsp;
    pmfl_chan_arr_t chans;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [16:0] rq[$];
    logic [14:0] iq[$];
    always #5 ref_clk = ~ref_clk;
    pmfl_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .img_rd(img_rd), .img_idx(img_idx));
    pmfl_top uut (.*);
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Expected image byte: a channel's 12 bytes count down from bit 95 of its snapshot
    function automatic logic [14:0] img_exp(input logic [7:0] i);
        logic [7:0] d;
        d = 8'h00;
        if (i >= 8'hc8 && i <= 8'hce) d = chans[0][95 - 8 * (i - 8'hc3) -: 8];
        if (i == 8'hcf) d = die_temp[15:8];
        if (i == 8'hd0) d = die_temp[7:0];
        if (i >= 8'hd1 && i <= 8'hdc) d = chans[3][95 - 8 * (i - 8'hd1) -: 8];
        if (i >= 8'hdd && i <= 8'he8) d = chans[2][95 - 8 * (i - 8'hdd) -: 8];
        if (i >= 8'he9 && i <= 8'hed) d = chans[1][95 - 8 * (i - 8'he9) -: 8];
        if (i < 8'hc8 || i > 8'hed) return 15'h0000;
        if (i <= 8'hd0) return {1'b1, 6'(8'hd0 - i), d};
        return {1'b1, 6'(8'h39 - (i - 8'hd1)), d};
    endfunction
    task automatic cmdq(input logic [7:0] c, input logic [1:0] p, input logic w,
        input logic [16:0] e);
        rq.push_back(e);
        host.rd_cmd(c, p, w);
    endtask
    task automatic imgq(input logic [7:0] i);
        iq.push_back(img_exp(i));
        host.rd_img(i);
    endtask
    // Answers are matched oldest-first; the falling edge sees them settled
    always @(negedge ref_clk) begin
        if (rsp_valid === 1'b1) chk(rsp, rq.size() ? rq.pop_front() : 17'h1ffff);
        if (img_rsp_valid === 1'b1) begin
            chk(17'(img_rsp), 17'(iq.size() ? iq.pop_front() : 15'h7fff));
        end
    end
    // Main sequence; ecc_clean low so the post-reset sample shows up
    initial begin
        int s;
        s = $urandom(86);
        {ecc_clean, restore_done, bulk_read_done, fault_log_written} = 4'h0;
        for (int k = 0; k < 12; k++) chans[k / 3][32 * (k % 3) +: 32] = $urandom();
        die_temp = 16'($urandom());
        maker_identity_word = 16'($urandom());
        lot_codes = $urandom();
        repeat (8) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        cmdq(8'h19, 2'h0, 1'b0, 17'h100b0);
        cmdq(8'h98, 2'h3, 1'b0, 17'h10011);
        cmdq(8'he7, 2'h1, 1'b1, {1'b1, maker_identity_word});
        for (int p = 0; p < 4; p++) cmdq(8'hc2, 2'(p), 1'b0, {9'h100, lot_codes[p]});
        cmdq(8'h19, 2'h0, 1'b1, 17'h00000);
        cmdq(8'h5a, 2'h0, 1'b0, 17'h00000);
        cmdq(8'hb6, 2'h0, 1'b1, 17'h10000);
        $display("test identification done");
        ecc_clean = 1'b1;
        cmdq(8'hb6, 2'h0, 1'b1, 17'h10000);
        bulk_read_done = 1'b1;
        cmdq(8'h98, 2'h0, 1'b0, 17'h10011);
        bulk_read_done = 1'b0;
        ecc_clean = 1'b0;
        cmdq(8'hb6, 2'h0, 1'b1, 17'h10020);
        restore_done = 1'b1;
        cmdq(8'hb6, 2'h0, 1'b1, 17'h10020);
        restore_done = 1'b0;
        cmdq(8'hb6, 2'h0, 1'b1, 17'h10000);
        $display("test ecc refresh done");
        fault_log_written = 1'b1;
        imgq(8'hc4);
        fault_log_written = 1'b0;
        chk(17'(fault_log_ram_status), 17'h1);
        for (int i = 8'hc5; i < 256; i++) imgq(8'(i));
        chk(17'(fault_log_ram_status), 17'h0);
        fault_log_written = 1'b1;
        imgq(8'hff);
        fault_log_written = 1'b0;
        chk(17'(fault_log_ram_status), 17'h1);
        imgq(8'hff);
        host.idle();
        chk(17'(fault_log_ram_status), 17'h0);
        $display("test image tail done");
        for (int t = 0; t < 20 && (rq.size() || iq.size()); t++) @(posedge ref_clk);
        if (rq.size() || iq.size()) n_mismatch++;
        wrap_up();
    end
endmodule // tb_pmfl_top
`default_nettype wire
